// >>> inc/rmc_pkg.sv
// Package: constants and types for the reset and reserved mode-code processor
package rmc_pkg;
	// ----------------------------------------
	// Mode codes
	// ----------------------------------------
	localparam logic [4:0] MC_RESET_TERM = 5'h08;
	localparam logic [4:0] MC_RSV_LO = 5'h09;
	localparam logic [4:0] MC_RSV_HI = 5'h0F;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_ILL = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;
	localparam logic [7:0] ADDR_DESC = 8'h14;
	localparam logic [7:0] ADDR_INFO = 8'h18;
	localparam logic [7:0] ADDR_BITW = 8'h1C;
	// Config bits
	localparam int CFG_UNDEFINED_MODE_INVALID_OPTION = 0;
	localparam int CFG_SOFTWARE_RESET_BIT = 1;
	localparam int CFG_W = 2;
	// Terminal status bits
	localparam int ST_MSG_ERROR_RECORD = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_BCR = 2;
	localparam int ST_TXSHUT_A = 3;
	localparam int ST_TXSHUT_B = 4;
	localparam int ST_TFINH = 5;
	localparam int ST_W = 6;
	// Descriptor control bits
	localparam int DC_ACC = 0;
	localparam int DC_BROADCAST_MSG_FLAG = 1;
	localparam int DC_PP = 2;
	localparam int DC_W = 3;
	// Message info word bits
	localparam int MI_BUS_IDENTITY_BIT = 0;
	localparam int MI_MSG_ERROR_RECORD = 1;
	localparam int MI_ILLEGAL_COMMAND_FLAG = 2;
	localparam int MI_TERMINAL_TO_TERMINAL_FLAG = 3;
	localparam int MI_GAP = 4;
	localparam int MI_WCT = 5;
	localparam int MI_W = 6;
	// Interrupt bits
	localparam int IRQ_MSGRX = 0;
	localparam int IRQ_BROADCAST_MSG_FLAG = 1;
	localparam int IRQ_ILLEGAL_COMMAND_FLAG = 2;
	localparam int IRQ_MSG_ERROR_RECORD = 3;
	localparam int IRQ_W = 4;
	localparam logic [15:0] BIT_WORD_CLR = 16'h0000;
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_WAIT = 3'b010,
		S_DONE = 3'b100
	} rmc_state_t;
endpackage : rmc_pkg

// >>> rtl/rmc_decode.sv
// Decoder: classifies a received mode command into its handling case
`timescale 1ns/1ps
module rmc_decode
	import rmc_pkg::*;
(
	input wire logic [4:0] mode_code, // Received mode code
	input wire logic tr_bit, // Transmit/receive bit
	input wire logic cmd_valid_word, // Command word passed validation
	input wire logic undefined_mode_invalid_option, // Invalidates T/R=0 codes
	input wire logic [15:0] ill_table, // Table bits: [7:0] T/R=1, [15:8] T/R=0
	output logic handled, // Code belongs to this block
	output logic ignore, // Message ignored completely
	output logic illegal, // Illegalization bit applies
	output logic is_reset // Reset-terminal code with T/R=1
);
	logic [2:0] idx;
	always_comb begin
		idx = mode_code[2:0];
		handled = (mode_code >= MC_RESET_TERM) && (mode_code <= MC_RSV_HI);
		is_reset = handled && tr_bit && (mode_code == MC_RESET_TERM);
		ignore = handled && (!cmd_valid_word || (!tr_bit && undefined_mode_invalid_option));
		// Reset code with T/R=1 is never illegalized here
		if (tr_bit) begin
			illegal = (mode_code != MC_RESET_TERM) && ill_table[idx];
		end else begin
			illegal = ill_table[8 + idx];
		end
	end
endmodule : rmc_decode

// >>> rtl/rmc_irq.sv
// Interrupt collector: sticky status, mask, write-one-to-clear
`timescale 1ns/1ps
module rmc_irq
	import rmc_pkg::*;
#(
	parameter int W = IRQ_W
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic [W-1:0] evt, // Event pulses
	input wire logic [W-1:0] clr, // Write-one-to-clear bits
	input wire logic mask_we, // Mask write strobe
	input wire logic [W-1:0] mask_d, // Mask write data
	output logic [W-1:0] status, // Sticky status
	output logic [W-1:0] mask, // Mask (1 enables)
	output logic irq // Level interrupt
);
	typedef struct packed {
		logic [W-1:0] st;
		logic [W-1:0] mk;
	} rmc_irq_t;
	rmc_irq_t q_r, q_nxt;
	always_comb begin
		q_nxt = q_r;
		// Set wins over a simultaneous clear
		q_nxt.st = (q_r.st & ~clr) | evt;
		if (mask_we) begin
			q_nxt.mk = mask_d;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
	assign status = q_r.st;
	assign mask = q_r.mk;
	assign irq = |(q_r.st & q_r.mk);
endmodule : rmc_irq

// >>> rtl/rmc_top.sv
// Mode-code processor for reset-terminal and reserved mode codes
`timescale 1ns/1ps
module rmc_top
	import rmc_pkg::*;
(
	input wire logic hclk, // Clock, 10 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response
	input wire logic cmd_stb, // Mode command received pulse
	input wire logic [4:0] cmd_mode_code, // Mode code field
	input wire logic cmd_tr, // T/R bit
	input wire logic cmd_broadcast_msg_flag, // Broadcast address
	input wire logic cmd_valid, // Command word valid
	input wire logic cmd_bus_b, // Received on bus B
	input wire logic cmd_data_follows, // Contiguous data word followed
	input wire logic status_sent, // Status word transmission done pulse
	output logic status_tx_req, // Request status word transmit pulse
	output logic master_reset_pin_req, // Software reset bit level
	output logic irq // Interrupt level
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		rmc_state_t st;
		logic [CFG_W-1:0] cfg;
		logic [15:0] ill;
		logic [ST_W-1:0] tstat;
		logic [DC_W-1:0] desc;
		logic [MI_W-1:0] info;
		logic [15:0] bitw;
		logic tx_req;
		logic rst_pend;
		logic aph_wr;
		logic aph_rd;
		logic [7:0] aph_addr;
		logic [31:0] rdata;
	} rmc_top_t;
	rmc_top_t q_r, q_nxt;

	logic handled, ignore, illegal, is_reset;
	logic [IRQ_W-1:0] evt, irq_clr, irq_st, irq_mk;
	logic mask_we;

	rmc_decode u_dec (
		.mode_code(cmd_mode_code),
		.tr_bit(cmd_tr),
		.cmd_valid_word(cmd_valid),
		.undefined_mode_invalid_option(q_r.cfg[CFG_UNDEFINED_MODE_INVALID_OPTION]),
		.ill_table(q_r.ill),
		.handled(handled),
		.ignore(ignore),
		.illegal(illegal),
		.is_reset(is_reset)
	);

	rmc_irq #(.W(IRQ_W)) u_irq (
		.hclk(hclk),
		.hresetn(hresetn),
		.evt(evt),
		.clr(irq_clr),
		.mask_we(mask_we),
		.mask_d(hwdata[IRQ_W-1:0]),
		.status(irq_st),
		.mask(irq_mk),
		.irq(irq)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	function automatic logic [31:0] read_mux(input logic [7:0] a, input rmc_top_t s,
		input logic [IRQ_W-1:0] ist, input logic [IRQ_W-1:0] imk);
		logic [31:0] d;
		d = '0;
		unique case (a)
			ADDR_CFG: d[CFG_W-1:0] = s.cfg;
			ADDR_ILL: d[15:0] = s.ill;
			ADDR_STAT: d[ST_W-1:0] = s.tstat;
			ADDR_IRQ_ST: d[IRQ_W-1:0] = ist;
			ADDR_IRQ_MSK: d[IRQ_W-1:0] = imk;
			ADDR_DESC: d[DC_W-1:0] = s.desc;
			ADDR_INFO: d[MI_W-1:0] = s.info;
			ADDR_BITW: d[15:0] = s.bitw;
			default: d = '0;
		endcase
		return d;
	endfunction : read_mux

	logic take;
	assign take = hsel && hready && htrans[1];
	assign mask_we = q_r.aph_wr && (q_r.aph_addr == ADDR_IRQ_MSK);
	assign irq_clr = (q_r.aph_wr && (q_r.aph_addr == ADDR_IRQ_ST)) ? hwdata[IRQ_W-1:0] : '0;

	// ----------------------------------------
	// Command handling
	// ----------------------------------------
	logic act;
	assign act = cmd_stb && handled && !ignore;

	always_comb begin
		q_nxt = q_r;
		evt = '0;
		q_nxt.tx_req = 1'b0;
		q_nxt.aph_wr = take && hwrite;
		q_nxt.aph_rd = take && !hwrite;
		q_nxt.aph_addr = take ? haddr[7:0] : q_r.aph_addr;
		if (take && !hwrite) begin
			q_nxt.rdata = read_mux(haddr[7:0], q_r, irq_st, irq_mk);
		end
		// Host writes; the reset code never touches cfg or table
		if (q_r.aph_wr) begin
			unique case (q_r.aph_addr)
				ADDR_CFG: q_nxt.cfg = hwdata[CFG_W-1:0];
				ADDR_ILL: q_nxt.ill = hwdata[15:0];
				ADDR_STAT: q_nxt.tstat = hwdata[ST_W-1:0];
				ADDR_BITW: q_nxt.bitw = hwdata[15:0];
				default: ;
			endcase
		end
		if (act) begin
			q_nxt.desc[DC_PP] = !q_r.desc[DC_PP];
			q_nxt.desc[DC_ACC] = !is_reset;
			q_nxt.info = '0;
			q_nxt.info[MI_BUS_IDENTITY_BIT] = cmd_bus_b;
			evt[IRQ_MSGRX] = 1'b1;
			if (cmd_data_follows) begin
				q_nxt.tstat[ST_MSG_ERROR_RECORD] = 1'b1;
				// Accessed flag is set here, the reset code included
				q_nxt.desc[DC_ACC] = 1'b1;
				q_nxt.desc[DC_BROADCAST_MSG_FLAG] = 1'b0;
				q_nxt.info[MI_MSG_ERROR_RECORD] = 1'b1;
				// Reset code counts as a gap fault whatever its T/R bit
				q_nxt.info[MI_GAP] = (cmd_mode_code == MC_RESET_TERM);
				q_nxt.info[MI_WCT] = (cmd_mode_code != MC_RESET_TERM);
				evt[IRQ_MSG_ERROR_RECORD] = 1'b1;
			end else begin
				q_nxt.desc[DC_BROADCAST_MSG_FLAG] = cmd_broadcast_msg_flag;
				q_nxt.tstat[ST_MSG_ERROR_RECORD] = illegal;
				if (illegal) begin
					q_nxt.info[MI_ILLEGAL_COMMAND_FLAG] = 1'b1;
					q_nxt.info[MI_MSG_ERROR_RECORD] = 1'b1;
					evt[IRQ_ILLEGAL_COMMAND_FLAG] = 1'b1;
				end
				// Reserved T/R=1 in-form case reports bus identity cleared
				if (cmd_tr && !is_reset && !illegal) begin
					q_nxt.info[MI_BUS_IDENTITY_BIT] = 1'b0;
				end
				if (cmd_broadcast_msg_flag && (!cmd_tr || is_reset)) begin
					if (!cmd_tr) begin
						q_nxt.tstat[ST_BCR] = 1'b1;
					end
					evt[IRQ_BROADCAST_MSG_FLAG] = 1'b1;
				end else begin
					q_nxt.tx_req = 1'b1;
				end
				if (is_reset) begin
					q_nxt.bitw = BIT_WORD_CLR;
					q_nxt.tstat[ST_TXSHUT_A] = 1'b0;
					q_nxt.tstat[ST_TXSHUT_B] = 1'b0;
					q_nxt.tstat[ST_TFINH] = 1'b0;
					q_nxt.rst_pend = 1'b1;
					q_nxt.st = cmd_broadcast_msg_flag ? S_DONE : S_WAIT;
				end
			end
		end
		// Post-status clear of message error, busy, broadcast-received
		unique case (q_r.st)
			S_IDLE: ;
			S_WAIT: begin
				if (status_sent) begin
					q_nxt.st = S_DONE;
				end
			end
			S_DONE: begin
				q_nxt.tstat[ST_MSG_ERROR_RECORD] = 1'b0;
				q_nxt.tstat[ST_BUSY] = 1'b0;
				q_nxt.tstat[ST_BCR] = 1'b0;
				q_nxt.rst_pend = 1'b0;
				q_nxt.st = S_IDLE;
			end
			default: q_nxt.st = S_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q_r <= '0;
			q_r.st <= S_IDLE;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign hrdata = q_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign status_tx_req = q_r.tx_req;
	assign master_reset_pin_req = q_r.cfg[CFG_SOFTWARE_RESET_BIT];
endmodule : rmc_top

// >>> verif/rmc_properties.sv
// Checker: port-level properties of the mode-code processor
`timescale 1ns/1ps
module rmc_properties
	import rmc_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic hsel, // Select
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic hready, // Bus ready
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Response
	input wire logic cmd_stb, // Command pulse
	input wire logic [4:0] cmd_mode_code, // Mode code
	input wire logic cmd_tr, // T/R bit
	input wire logic cmd_broadcast_msg_flag, // Broadcast
	input wire logic cmd_valid, // Word valid
	input wire logic cmd_data_follows, // Data word followed
	input wire logic status_tx_req, // Status request
	input wire logic master_reset_pin_req, // Software reset level
	input wire logic irq // Interrupt
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Bus writes may legally move config and interrupt state
	wire logic wr = hsel && hready && htrans[1] && hwrite;
	wire logic go = cmd_stb && cmd_valid && !cmd_data_follows && !cmd_broadcast_msg_flag;
	wire logic rsv = cmd_mode_code >= MC_RSV_LO && cmd_mode_code <= MC_RSV_HI;
	AST_OKAY:
	assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	AST_RST_TX:
	assert property (go && cmd_tr && cmd_mode_code == MC_RESET_TERM |=> status_tx_req)
		else $error("reset code got no status");
	AST_RSV_TX:
	assert property (go && cmd_tr && rsv |=> status_tx_req)
		else $error("reserved code got no status");
	AST_BC_QUIET:
	assert property (cmd_stb && cmd_broadcast_msg_flag && (!cmd_tr || !rsv) |=> !status_tx_req)
		else $error("broadcast answered");
	AST_DF_QUIET:
	assert property (cmd_stb && cmd_data_follows |=> !status_tx_req)
		else $error("status after data word");
	AST_IGN:
	assert property (cmd_stb && !cmd_valid && !$past(wr) |=> !status_tx_req && $stable(irq))
		else $error("invalid word not ignored");
	AST_TX_CAUSE:
	assert property (status_tx_req |-> $past(cmd_stb))
		else $error("status request without command");
	AST_CFG_KEEP:
	assert property (cmd_stb && !$past(wr) |=> $stable(master_reset_pin_req))
		else $error("command moved config");
endmodule : rmc_properties

// >>> verif/rmc_bc_model.sv
// Bus controller stand-in: answers status requests after a set delay
`timescale 1ns/1ps
module rmc_bc_model (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic status_tx_req, // Status word request
	input wire logic [2:0] lat, // Reply delay in cycles
	output logic status_sent // Status word done pulse
);
	logic [3:0] cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 4'h0;
			status_sent <= 1'b0;
		end else begin
			status_sent <= (cnt == 4'h1);
			if (status_tx_req)
				cnt <= {1'b0, lat} + 4'h1;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule : rmc_bc_model

// >>> verif/rmc_top_tb_top.sv
// Testbench: random mode commands with register checks
`timescale 1ns/1ps
module rmc_top_tb_top;
	import rmc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, lat = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v, w, d0, i0, ie;
	logic hreadyout, hresp, status_sent, status_tx_req, master_reset_pin_req, irq;
	logic cmd_stb = 1'b0, cmd_tr = 1'b0, cmd_broadcast_msg_flag = 1'b0, cmd_valid = 1'b0;
	logic cmd_bus_b = 1'b0, cmd_data_follows = 1'b0, tr, bc, df, ign, ill, rst, bsid;
	logic [4:0] cmd_mode_code = 5'h00, mc;
	wire logic hready = hreadyout;
	int fails = 0, checked = 0, cyc = 0, txn = 0, t0;
	rmc_top u_rmc_top (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.cmd_stb(cmd_stb),
		.cmd_mode_code(cmd_mode_code),
		.cmd_tr(cmd_tr),
		.cmd_broadcast_msg_flag(cmd_broadcast_msg_flag),
		.cmd_valid(cmd_valid),
		.cmd_bus_b(cmd_bus_b),
		.cmd_data_follows(cmd_data_follows),
		.status_sent(status_sent),
		.status_tx_req(status_tx_req),
		.master_reset_pin_req(master_reset_pin_req),
		.irq(irq)
	);
	rmc_bc_model u_rmc_bc_model (
		.hclk(hclk),
		.hresetn(hresetn),
		.status_tx_req(status_tx_req),
		.lat(lat),
		.status_sent(status_sent)
	);
	initial forever #50 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (status_tx_req === 1'b1)
			txn <= txn + 1;
		if (cyc == 30000) begin
			fails++;
			tally_and_finish;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		{hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, wr};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	task automatic cmd(input logic [4:0] m, input logic t, b, bb, d, vl);
		{cmd_mode_code, cmd_tr, cmd_broadcast_msg_flag, cmd_bus_b, cmd_data_follows} <= {m, t, b, bb, d};
		{cmd_valid, cmd_stb} <= {vl, 1'b1};
		@(posedge hclk);
		cmd_stb <= 1'b0;
		// Slowest reply is 8 cycles, then the late status clear
		repeat (14) @(posedge hclk);
	endtask : cmd
	task automatic tally_and_finish;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		void'($urandom(68687));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Whole map is zero out of reset, the hole at 0x20 too
		for (int a = 0; a <= 32; a += 4)
			rdchk(8'(a), 32'h0);
		ahb(1'b1, 8'h20, 32'hFFFFFFFF);
		rdchk(8'h20, 32'h0);
		$display("reset map test done");
		for (int i = 0; i < 100; i++) begin
			v = $urandom;
			w = $urandom;
			mc = {2'b01, v[10:8]};
			tr = v[1];
			df = v[3] & v[4];
			bc = v[2] & (!tr | mc == MC_RESET_TERM);
			ign = !(v[5] | v[6]) || (!tr && v[0]);
			ill = !ign && w[{~tr, mc[2:0]}] && !(tr && mc == MC_RESET_TERM);
			rst = !ign && tr && mc == MC_RESET_TERM && !df;
			bsid = (tr && mc != MC_RESET_TERM && !ill && !df) ? 1'b0 : v[7];
			ie = {26'h0, df && mc != MC_RESET_TERM, df && mc == MC_RESET_TERM, 1'b0,
				ill && !df, ill || df, bsid};
			ahb(1'b1, ADDR_CFG, {30'h0, v[9], v[0]});
			ahb(1'b1, ADDR_ILL, {16'h0, w[15:0]});
			chk(32'(master_reset_pin_req), 32'(v[9]));
			ahb(1'b1, ADDR_STAT, {26'h0, v[21:16]});
			ahb(1'b1, ADDR_BITW, {16'h0, w[31:16]});
			ahb(1'b1, ADDR_IRQ_ST, 32'hF);
			ahb(1'b1, ADDR_IRQ_MSK, {31'h0, v[15]});
			ahb(1'b0, ADDR_DESC, 32'h0);
			d0 = rd;
			chk(32'(irq), 32'h0);
			ahb(1'b0, ADDR_INFO, 32'h0);
			i0 = rd;
			t0 = txn;
			lat <= v[14:12];
			cmd(mc, tr, bc, v[7], df, v[5] | v[6]);
			chk(32'(txn - t0), 32'(!ign && !df && !bc));
			rdchk(ADDR_STAT, ign ? {26'h0, v[21:16]} : rst ? 32'h0 : {26'h0, v[21:19],
				v[18] | (!tr && bc && !df), v[17], ill || df});
			rdchk(ADDR_BITW, rst ? 32'h0 : {16'h0, w[31:16]});
			rdchk(ADDR_CFG, {30'h0, v[9], v[0]});
			rdchk(ADDR_DESC, ign ? d0 : {29'h0, ~d0[DC_PP], bc && !df, !rst});
			rdchk(ADDR_INFO, ign ? i0 : ie);
			chk(32'(irq), 32'(!ign && v[15]));
			ahb(1'b0, ADDR_IRQ_ST, 32'h0);
			chk(32'(rd[IRQ_MSGRX]), 32'(!ign));
			chk(rd, {28'h0, !ign && df, ill && !df, !ign && bc && !df, !ign});
		end
		$display("random command test done");
		// Corner: a code outside this block's range must leave it untouched
		ahb(1'b0, ADDR_DESC, 32'h0);
		d0 = rd;
		t0 = txn;
		cmd(5'h10, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		chk(32'(txn - t0), 32'h0);
		rdchk(ADDR_DESC, d0);
		$display("foreign code test done");
		tally_and_finish;
	end
endmodule : rmc_top_tb_top
bind rmc_top rmc_properties u_rmc_properties (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.cmd_stb(cmd_stb),
	.cmd_mode_code(cmd_mode_code),
	.cmd_tr(cmd_tr),
	.cmd_broadcast_msg_flag(cmd_broadcast_msg_flag),
	.cmd_valid(cmd_valid),
	.cmd_data_follows(cmd_data_follows),
	.status_tx_req(status_tx_req),
	.master_reset_pin_req(master_reset_pin_req),
	.irq(irq)
);
